// ---- bench/meas_src_model.sv ----
`timescale 1ns/1ps
module meas_src_model #(
    parameter int PER   = 40,
    parameter int MIN_W = 1250
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Requested pin level
    input  wire logic trig_req,
    // Towards the block
    output logic      cycle_start,
    output logic      trig_pin
);
    int ph;
    int held;
    // Fixed measuring rate, whatever the trigger does
    always_ff @(posedge clk) begin
        ph <= (!rst_n || ph == PER - 1) ? 0 : ph + 1;
        cycle_start <= rst_n && ph == PER - 1;
    end
    // Pin follows request only once 5 us have passed, so pulse and pause both last over 31 cycles
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_pin <= 1'b0;
            held <= MIN_W;
        end else if (trig_pin != trig_req && held >= MIN_W) begin
            trig_pin <= trig_req;
            held <= 0;
        end else begin
            held <= held + 1;
        end
    end
endmodule

// ---- bench/meas_trig_chk.sv ----
`timescale 1ns/1ps
module meas_trig_chk #(
    parameter int CNT_W = 32
) (
    // Clock, reset and pipeline inputs
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic             cycle_start,
    input wire logic             peak_valid,
    input wire logic [7:0]       peak_lo_pct,
    input wire logic [7:0]       peak_hi_pct,
    // Watched outputs
    input wire logic             process_cycle,
    input wire logic             avg_hold,
    input wire logic             expo_end,
    input wire logic [15:0]      expo_time_us,
    input wire logic             peak_accept,
    input wire logic [7:0]       mask_start,
    input wire logic [7:0]       mask_end,
    input wire logic [CNT_W-1:0] value_count,
    input wire logic             trig_diff_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Gating splits cycles, never adds or drops one
    AST_GATE_SPLIT: assert property (cycle_start == (process_cycle || avg_hold))
        else $error("cycle neither processed nor held");
    AST_GATE_EXCL: assert property (!(process_cycle && avg_hold))
        else $error("cycle both processed and held");
    // Exposure end fixed 25 clocks after start
    AST_EXPO_END: assert property (cycle_start |-> ##25 expo_end)
        else $error("exposure end late or missing");
    AST_EXPO_ONE: assert property (expo_end |=> !expo_end)
        else $error("exposure end longer than one clock");
    // Peak acceptance tied to the mask window both ways
    AST_PEAK_IN: assert property (peak_accept |-> peak_valid && peak_lo_pct >= mask_start && peak_hi_pct <= mask_end)
        else $error("peak accepted outside window");
    AST_PEAK_OK: assert property (peak_valid && peak_lo_pct >= mask_start && peak_hi_pct <= mask_end |-> peak_accept)
        else $error("peak inside window dropped");
    AST_EXPO_CAP: assert property (expo_time_us <= 16'h2710)
        else $error("exposure above ceiling");
    AST_DIFF_AT: assert property (trig_diff_valid |-> $past(cycle_start))
        else $error("time difference off the cycle grid");
    // Counter only steps by one or clears
    AST_CNT_STEP: assert property ($changed(value_count) |-> value_count == $past(value_count) + 1'b1 || value_count == '0)
        else $error("value counter jumped");
endmodule

// ---- bench/measurement_trigger_control_tb_top.sv ----
`timescale 1ns/1ps
module measurement_trigger_control_tb_top;
    // Bench state, all inputs defined at time zero
    logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0, peak_lo_pct = 0, peak_hi_pct = 0;
    logic [31:0] pwdata = 0, enc_count = 0, prdata, timestamp, trig_diff, value_count, rd;
    logic        peak_valid = 0, signal_saturated = 0, signal_low = 0, trig_req = 0, er;
    logic        pready, pslverr, trig_pin, cycle_start, process_cycle, avg_hold, expo_end;
    logic        avg_enable, peak_accept, trig_diff_valid;
    logic [7:0]  mask_start, mask_end, modulation_pct, threshold_pct;
    logic [15:0] expo_time_us, ea;
    int          err_count = 0, check_count = 0, p, h;

    measurement_trigger_control u_dut (.*);
    meas_src_model u_src (.clk(clk), .rst_n(rst_n), .trig_req(trig_req), .cycle_start(cycle_start),
                          .trig_pin(trig_pin));

    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Count processed and held cycles over n cycle starts
    task automatic cnt(input int n);
        p = 0;
        h = 0;
        repeat (n) begin
            do @(negedge clk); while (cycle_start !== 1'b1);
            p += (process_cycle === 1'b1);
            h += (avg_hold === 1'b1);
        end
    endtask

    task automatic t_defaults();
        apb(0, 8'h00, 0);
        chk(rd, 0);
        apb(0, 8'h20, 0);
        chk(rd, 32'h0232_6400);
        chk({threshold_pct, modulation_pct, mask_end, mask_start}, 32'h0232_6400);
        cnt(3);
        chk(p, 3);
        chk(h, 0);
        apb(0, 8'hfc, 0);
        chk(rd, 0);
        chk(er, 1);
    endtask

    task automatic t_soft();
        apb(1, 8'h04, 2);
        apb(1, 8'h00, 3);
        apb(1, 8'h08, 2);
        cnt(2);
        chk(p, 0);
        chk(value_count, 0);
        chk(h, 2);
        chk(timestamp < 32'd100, 1);
        apb(1, 8'h08, 1);
        cnt(3);
        chk(p, 2);
        chk(trig_diff, 0);
        cnt(2);
        chk(trig_diff, 3);
        chk(value_count, 2);
        apb(1, 8'h00, 32'h13);
        cnt(1);
        apb(1, 8'h08, 1);
        cnt(6);
        chk(p, 6);
    endtask

    // Rising edge, level both ways, then falling edge
    task automatic t_pin();
        apb(1, 8'h04, 3);
        apb(1, 8'h00, 32'h0a);
        trig_req <= 1'b1;
        cnt(40);
        chk(p, 3);
        @(posedge clk);
        trig_req <= 1'b0;
        cnt(40);
        chk(p, 0);
        apb(1, 8'h00, 32'h09);
        cnt(2);
        chk(p, 0);
        @(posedge clk);
        trig_req <= 1'b1;
        cnt(3);
        chk(p, 3);
        apb(1, 8'h00, 32'h01);
        cnt(3);
        chk(p, 0);
        @(posedge clk);
        trig_req <= 1'b0;
        cnt(35);
        cnt(3);
        chk(p, 3);
        apb(1, 8'h00, 32'h02);
        trig_req <= 1'b1;
        cnt(35);
        chk(p, 0);
        @(posedge clk);
        trig_req <= 1'b0;
        cnt(40);
        chk(p, 3);
    endtask

    task automatic t_enc();
        apb(1, 8'h0c, 10);
        apb(1, 8'h10, 100);
        apb(1, 8'h14, 10);
        apb(1, 8'h00, 4);
        cnt(3);
        chk(p, 0);
        @(posedge clk);
        enc_count <= 32'd20;
        cnt(8);
        chk(p, 3);
    endtask

    task automatic t_expo();
        apb(1, 8'h1c, 32'h0032_4e20);
        apb(1, 8'h18, 1);
        cnt(2);
        chk(expo_time_us, 16'h2710);
        apb(1, 8'h1c, 32'h0032_0064);
        apb(1, 8'h18, 2);
        cnt(2);
        ea = expo_time_us;
        cnt(1);
        chk(ea + expo_time_us, 16'h0096);
        chk(avg_enable, 0);
        apb(1, 8'h18, 3);
        cnt(2);
        chk(expo_time_us, 16'h0064);
        @(posedge clk);
        signal_saturated <= 1'b1;
        cnt(2);
        chk(expo_time_us, 16'h0032);
        apb(1, 8'h18, 0);
        cnt(8);
        ea = expo_time_us;
        cnt(1);
        chk(expo_time_us, ea);
        chk(ea < 16'h0064, 1);
    endtask

    // Window 20..80 percent, edges included
    task automatic t_peak();
        logic [15:0] pk [4] = '{16'h0a32, 16'h1450, 16'h1350, 16'h1451};
        logic        ok [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
        apb(1, 8'h20, 32'h0232_5014);
        foreach (pk[i]) begin
            @(posedge clk);
            peak_valid <= 1'b1;
            {peak_lo_pct, peak_hi_pct} <= pk[i];
            @(negedge clk);
            chk(peak_accept, ok[i]);
        end
        @(posedge clk);
        peak_valid <= 1'b0;
    endtask

    task automatic give_verdict();
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence after two reset cycles
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_defaults();
        t_soft();
        t_pin();
        t_enc();
        t_expo();
        t_peak();
        give_verdict();
    end

    // Watchdog, about three times the expected run
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule

bind measurement_trigger_control meas_trig_chk #(.CNT_W(CNT_W)) u_chk (.*);

// ---- hdl/meas_trig_params.svh ----
`ifndef MEAS_TRIG_PARAMS_SVH
`define MEAS_TRIG_PARAMS_SVH

// Register byte offsets
`define OFS_TRIG_CFG      8'h00
`define OFS_TRIG_COUNT    8'h04
`define OFS_SW_CMD        8'h08
`define OFS_ENC_LOWER     8'h0c
`define OFS_ENC_UPPER     8'h10
`define OFS_ENC_INCR      8'h14
`define OFS_EXPO_CFG      8'h18
`define OFS_EXPO_TIMES    8'h1c
`define OFS_PEAK_CFG      8'h20
`define OFS_STATUS        8'h24
`define OFS_VALUE_COUNT   8'h28
`define OFS_TIMESTAMP     8'h2c
`define OFS_TRIG_DIFF     8'h30

// Field positions in the trigger config word
`define TCFG_MODE_LSB     0
`define TCFG_POL_BIT      3
`define TCFG_INF_BIT      4
// Software command bits
`define CMD_TRIGGER_BIT   0
`define CMD_RESET_CNT_BIT 1
// Exposure config field
`define ECFG_MODE_LSB     0

// Reset values
`define RST_TRIG_CFG      32'h0000_0000
`define RST_TRIG_COUNT    32'h0000_0001
`define RST_EXPO_TIMES    32'h0032_0064
`define RST_EXPO_T1       16'h0064
`define RST_EXPO_T2       16'h0032
`define RST_MASK_START    8'h00
`define RST_MASK_END      8'h64
`define RST_MODULATION    8'h32
`define RST_THRESHOLD     8'h02

// Limits and timing
`define EXPO_MAX_US       16'h2710
`define PCT_FULL          8'h64
`define EXPO_END_NS       100
`define CLK_PERIOD_NS     4
`define EXPO_END_CYC      ((`EXPO_END_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TRIG_PULSE_US     5
`define DIFF_LATENCY      3
`define SETTLE_MAX        7

`endif

// ---- hdl/meas_trig_pkg.sv ----
package meas_trig_pkg;
    // Trigger source selection
    typedef enum logic [2:0] {
        TRIG_INACTIVE = 3'h0,
        TRIG_LEVEL    = 3'h1,
        TRIG_EDGE     = 3'h2,
        TRIG_SOFTWARE = 3'h3,
        TRIG_ENCODER  = 3'h4
    } trig_mode_t;

    // Exposure sequencing
    typedef enum logic [1:0] {
        EXPO_MEASURE   = 2'h0,
        EXPO_MANUAL    = 2'h1,
        EXPO_ALTERNATE = 2'h2,
        EXPO_AUTO_TWO  = 2'h3
    } expo_mode_t;

    // Acquisition gate state, one-hot
    typedef enum logic [2:0] {
        ACQ_IDLE  = 3'b001,
        ACQ_RUN   = 3'b010,
        ACQ_COUNT = 3'b100
    } acq_state_t;
endpackage

// ---- hdl/measurement_trigger_control.sv ----
// Overview of operation
// - Inactive default: acquire continuously from reset
// - Triggering gates cycles, never changes rate
// - Level mode records while level present
// - Edge mode starts counted or unlimited run
// - Software command starts counted or unlimited run
// - Encoder triggers within limits at increments
// - Process array only after valid trigger, except every cycle in inactive mode
// - Averaging keeps values from earlier triggers
// - Time difference from cycle start to trigger
// - Time difference emitted three cycles later
// - Exposure ends fixed 100 ns after start
// - Counter from zero, host reset clears both
// - Mask window percent, default 0 to 100
// - Accept peak only wholly inside window
// - Manual exposure fixed, capped at 10000 us
// - Alternating mode toggles, ignores video averaging
// - Auto two-time picks better exposure per cycle
// - Measurement mode regulates exposure, settles within seven
// - Modulation evaluated per peak, default 50 %
// - Threshold percent of signal, default 2 %
`timescale 1ns/1ps
`include "meas_trig_params.svh"

module measurement_trigger_control #(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // External trigger pin and encoder
    input  wire logic                      trig_pin,
    input  wire logic [31:0]               enc_count,
    // Measurement pipeline
    input  wire logic                      cycle_start,
    input  wire logic                      peak_valid,
    input  wire logic [7:0]                peak_lo_pct,
    input  wire logic [7:0]                peak_hi_pct,
    input  wire logic                      signal_saturated,
    input  wire logic                      signal_low,
    // Gated outputs towards processing
    output logic                           process_cycle,
    output logic                           avg_hold,
    output logic                           expo_end,
    output logic      [15:0]               expo_time_us,
    output logic                           avg_enable,
    output logic                           peak_accept,
    output logic      [7:0]                mask_start,
    output logic      [7:0]                mask_end,
    output logic      [7:0]                modulation_pct,
    output logic      [7:0]                threshold_pct,
    output logic      [CNT_W-1:0]          value_count,
    output logic      [31:0]               timestamp,
    output logic      [31:0]               trig_diff,
    output logic                           trig_diff_valid
);
    import meas_trig_pkg::*;

    // Clamp an exposure request to the settable range
    function automatic logic [15:0] clamp_expo(input logic [15:0] t);
        clamp_expo = (t > `EXPO_MAX_US) ? `EXPO_MAX_US : t;
    endfunction

    // Percent window containment
    function automatic logic inside_window(input logic [7:0] lo, input logic [7:0] hi,
                                           input logic [7:0] ws, input logic [7:0] we);
        inside_window = (lo >= ws) && (hi <= we) && (lo <= hi);
    endfunction

    // Configuration registers
    logic [31:0] trig_cfg, next_trig_cfg;
    logic [31:0] trig_count, next_trig_count;
    logic [31:0] enc_lower, next_enc_lower;
    logic [31:0] enc_upper, next_enc_upper;
    logic [31:0] enc_incr, next_enc_incr;
    logic [1:0]  expo_cfg, next_expo_cfg;
    logic [15:0] expo_t1, next_expo_t1;
    logic [15:0] expo_t2, next_expo_t2;
    logic [7:0]  next_mask_start, next_mask_end, next_modulation, next_threshold;
    logic        sw_trig, next_sw_trig;
    logic        cnt_clear, next_cnt_clear;
    logic [31:0] next_prdata;

    logic        wr_en;
    assign wr_en   = psel && penable && pwrite;
    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;

    logic mapped;
    always_comb begin
        case (paddr)
            `OFS_TRIG_CFG, `OFS_TRIG_COUNT, `OFS_SW_CMD, `OFS_ENC_LOWER, `OFS_ENC_UPPER,
            `OFS_ENC_INCR, `OFS_EXPO_CFG, `OFS_EXPO_TIMES, `OFS_PEAK_CFG, `OFS_STATUS,
            `OFS_VALUE_COUNT, `OFS_TIMESTAMP, `OFS_TRIG_DIFF: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;

    trig_mode_t mode;
    logic       pol_high, infinite;
    assign mode     = trig_mode_t'(trig_cfg[`TCFG_MODE_LSB +: 3]);
    assign pol_high = trig_cfg[`TCFG_POL_BIT];
    assign infinite = trig_cfg[`TCFG_INF_BIT];

    acq_state_t state, next_state;
    logic [31:0] remaining, next_remaining;

    // Register writes; command bits are one-cycle pulses
    always_comb begin
        next_trig_cfg   = trig_cfg;
        next_trig_count = trig_count;
        next_enc_lower  = enc_lower;
        next_enc_upper  = enc_upper;
        next_enc_incr   = enc_incr;
        next_expo_cfg   = expo_cfg;
        next_expo_t1    = expo_t1;
        next_expo_t2    = expo_t2;
        next_mask_start = mask_start;
        next_mask_end   = mask_end;
        next_modulation = modulation_pct;
        next_threshold  = threshold_pct;
        next_sw_trig    = 1'b0;
        next_cnt_clear  = 1'b0;
        if (wr_en) begin
            case (paddr)
                `OFS_TRIG_CFG:   next_trig_cfg = pwdata;
                `OFS_TRIG_COUNT: next_trig_count = pwdata;
                `OFS_SW_CMD: begin
                    next_sw_trig   = pwdata[`CMD_TRIGGER_BIT];
                    next_cnt_clear = pwdata[`CMD_RESET_CNT_BIT];
                end
                `OFS_ENC_LOWER:  next_enc_lower = pwdata;
                `OFS_ENC_UPPER:  next_enc_upper = pwdata;
                `OFS_ENC_INCR:   next_enc_incr = pwdata;
                `OFS_EXPO_CFG:   next_expo_cfg = pwdata[`ECFG_MODE_LSB +: 2];
                `OFS_EXPO_TIMES: begin
                    next_expo_t1 = clamp_expo(pwdata[15:0]);
                    next_expo_t2 = clamp_expo(pwdata[31:16]);
                end
                `OFS_PEAK_CFG: begin
                    // Out-of-range mask percentages saturate at the full span; modulation and threshold are taken as written
                    next_mask_start = (pwdata[7:0] > `PCT_FULL) ? `PCT_FULL : pwdata[7:0];
                    next_mask_end   = (pwdata[15:8] > `PCT_FULL) ? `PCT_FULL : pwdata[15:8];
                    next_modulation = pwdata[23:16];
                    next_threshold  = pwdata[31:24];
                end
                default: ;
            endcase
        end
    end

    // Read mux
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `OFS_TRIG_CFG:    next_prdata = trig_cfg;
                `OFS_TRIG_COUNT:  next_prdata = trig_count;
                `OFS_ENC_LOWER:   next_prdata = enc_lower;
                `OFS_ENC_UPPER:   next_prdata = enc_upper;
                `OFS_ENC_INCR:    next_prdata = enc_incr;
                `OFS_EXPO_CFG:    next_prdata = {30'h0, expo_cfg};
                `OFS_EXPO_TIMES:  next_prdata = {expo_t2, expo_t1};
                `OFS_PEAK_CFG:    next_prdata = {threshold_pct, modulation_pct, mask_end, mask_start};
                `OFS_STATUS:      next_prdata = {29'h0, state};
                `OFS_VALUE_COUNT: next_prdata = 32'(value_count);
                `OFS_TIMESTAMP:   next_prdata = timestamp;
                `OFS_TRIG_DIFF:   next_prdata = trig_diff;
                default:          next_prdata = 32'h0000_0000;
            endcase
        end else if (psel && penable) begin
            next_prdata = prdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_cfg       <= `RST_TRIG_CFG;
            trig_count     <= `RST_TRIG_COUNT;
            enc_lower      <= 32'h0000_0000;
            enc_upper      <= 32'hffff_ffff;
            enc_incr       <= 32'h0000_0001;
            expo_cfg       <= EXPO_MEASURE;
            expo_t1        <= `RST_EXPO_T1;
            expo_t2        <= `RST_EXPO_T2;
            mask_start     <= `RST_MASK_START;
            mask_end       <= `RST_MASK_END;
            modulation_pct <= `RST_MODULATION;
            threshold_pct  <= `RST_THRESHOLD;
            sw_trig        <= 1'b0;
            cnt_clear      <= 1'b0;
            prdata         <= 32'h0000_0000;
        end else begin
            trig_cfg       <= next_trig_cfg;
            trig_count     <= next_trig_count;
            enc_lower      <= next_enc_lower;
            enc_upper      <= next_enc_upper;
            enc_incr       <= next_enc_incr;
            expo_cfg       <= next_expo_cfg;
            expo_t1        <= next_expo_t1;
            expo_t2        <= next_expo_t2;
            mask_start     <= next_mask_start;
            mask_end       <= next_mask_end;
            modulation_pct <= next_modulation;
            threshold_pct  <= next_threshold;
            sw_trig        <= next_sw_trig;
            cnt_clear      <= next_cnt_clear;
            prdata         <= next_prdata;
        end
    end

    // Trigger pin synchroniser; only stage two and later are read
    logic trig_s1, trig_s2, trig_s3;
    logic [31:0] enc_next_pos, next_enc_next_pos;
    logic trig_event, level_active, enc_hit;
    assign level_active = (trig_s2 == pol_high);
    assign enc_hit      = (enc_count >= enc_lower) && (enc_count <= enc_upper)
                          && (enc_count >= enc_next_pos);
    always_comb begin
        case (mode)
            TRIG_EDGE:     trig_event = pol_high ? (trig_s2 && !trig_s3) : (!trig_s2 && trig_s3);
            TRIG_SOFTWARE: trig_event = sw_trig;
            TRIG_ENCODER:  trig_event = enc_hit;
            default:       trig_event = 1'b0;
        endcase
    end

    // Encoder position of next trigger, advanced by the increment
    always_comb begin
        next_enc_next_pos = enc_next_pos;
        if (mode != TRIG_ENCODER)
            next_enc_next_pos = enc_lower;
        else if (enc_hit)
            next_enc_next_pos = enc_count + enc_incr;
    end

    // Gate machine: triggers arm it; cycle rate is never touched
    always_comb begin
        next_state     = state;
        next_remaining = remaining;
        case (state)
            ACQ_IDLE: begin
                if (trig_event) begin
                    next_state     = infinite ? ACQ_RUN : ACQ_COUNT;
                    next_remaining = trig_count;
                end
            end
            ACQ_RUN: ;
            ACQ_COUNT: begin
                if (cycle_start) begin
                    if (remaining <= 32'h0000_0001)
                        next_state = ACQ_IDLE;
                    next_remaining = remaining - 32'h0000_0001;
                end
            end
            default: next_state = ACQ_IDLE;
        endcase
        // Reconfiguration drops any running acquisition
        if (mode == TRIG_INACTIVE || mode == TRIG_LEVEL || trig_cfg != next_trig_cfg)
            next_state = ACQ_IDLE;
    end

    logic gate_open;
    assign gate_open = (mode == TRIG_INACTIVE) ||
                       (mode == TRIG_LEVEL && level_active) ||
                       (state != ACQ_IDLE);
    assign process_cycle = cycle_start && gate_open;
    // Ungated cycles stay out of the average so older triggered values persist
    assign avg_hold = cycle_start && !gate_open;
    assign avg_enable = (expo_cfg != EXPO_ALTERNATE);
    assign peak_accept = peak_valid && inside_window(peak_lo_pct, peak_hi_pct, mask_start, mask_end);

    // Trigger time difference and three-stage delay
    logic [31:0] cyc_timer, next_cyc_timer;
    logic [31:0] diff_pipe [`DIFF_LATENCY];
    logic [`DIFF_LATENCY-1:0] diff_vld;
    logic [31:0] next_trig_diff;
    logic        next_diff_valid;
    always_comb begin
        next_cyc_timer  = cycle_start ? 32'h0000_0001 : cyc_timer + 32'h0000_0001;
        next_trig_diff  = trig_diff;
        next_diff_valid = 1'b0;
        if (cycle_start && diff_vld[`DIFF_LATENCY-1]) begin
            next_trig_diff  = diff_pipe[`DIFF_LATENCY-1];
            next_diff_valid = 1'b1;
        end
    end

    // Exposure end timer and exposure selection
    logic [7:0]  expo_tmr;
    logic [7:0]  next_expo_tmr;
    logic        alt_phase, next_alt_phase;
    logic [15:0] auto_expo, next_auto_expo;
    logic [15:0] next_expo_time;
    logic [2:0]  settle, next_settle;
    always_comb begin
        next_expo_tmr  = cycle_start ? 8'(`EXPO_END_CYC) : ((expo_tmr != 8'h00) ? expo_tmr - 8'h01 : 8'h00);
        next_alt_phase = alt_phase;
        next_auto_expo = auto_expo;
        next_settle    = settle;
        next_expo_time = expo_time_us;
        if (cycle_start) begin
            case (expo_cfg)
                EXPO_MANUAL: next_expo_time = expo_t1;
                EXPO_ALTERNATE: begin
                    next_alt_phase = !alt_phase;
                    next_expo_time = alt_phase ? expo_t2 : expo_t1;
                end
                EXPO_AUTO_TWO: next_expo_time = signal_saturated ? expo_t2 : expo_t1;
                default: begin
                    // Halve or double per cycle; bounded steps settle within seven
                    if (settle != 3'(`SETTLE_MAX - 1) && (signal_saturated || signal_low)) begin
                        next_settle    = settle + 3'h1;
                        next_auto_expo = signal_saturated ? (auto_expo >> 1)
                                                          : clamp_expo({auto_expo[14:0], 1'b1});
                    end else if (!signal_saturated && !signal_low) begin
                        next_settle = 3'h0;
                    end
                    next_expo_time = next_auto_expo;
                end
            endcase
        end
    end
    assign expo_end = (expo_tmr == 8'h01);

    // Value counter and timestamp
    logic [CNT_W-1:0] next_value_count;
    logic [31:0]      next_timestamp;
    always_comb begin
        next_value_count = process_cycle ? value_count + CNT_W'(1) : value_count;
        next_timestamp   = timestamp + 32'h0000_0001;
        if (cnt_clear) begin
            next_value_count = '0;
            next_timestamp   = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_s1         <= 1'b0;
            trig_s2         <= 1'b0;
            trig_s3         <= 1'b0;
            enc_next_pos    <= 32'h0000_0000;
            state           <= ACQ_IDLE;
            remaining       <= 32'h0000_0000;
            cyc_timer       <= 32'h0000_0000;
            for (int i = 0; i < `DIFF_LATENCY; i++)
                diff_pipe[i] <= 32'h0000_0000;
            diff_vld        <= '0;
            trig_diff       <= 32'h0000_0000;
            trig_diff_valid <= 1'b0;
            expo_tmr        <= 8'h00;
            alt_phase       <= 1'b0;
            auto_expo       <= `RST_EXPO_T1;
            settle          <= 3'h0;
            expo_time_us    <= `RST_EXPO_T1;
            value_count     <= '0;
            timestamp       <= 32'h0000_0000;
        end else begin
            trig_s1         <= trig_pin;
            trig_s2         <= trig_s1;
            trig_s3         <= trig_s2;
            enc_next_pos    <= next_enc_next_pos;
            state           <= next_state;
            remaining       <= next_remaining;
            cyc_timer       <= next_cyc_timer;
            // Stage 0 holds this cycle's trigger; one on the start edge wins over the clear
            if (trig_event || cycle_start) begin
                diff_pipe[0] <= cycle_start ? 32'h0000_0000 : cyc_timer;
                diff_vld[0]  <= trig_event;
            end
            if (cycle_start) begin
                for (int i = 1; i < `DIFF_LATENCY; i++) begin
                    diff_pipe[i] <= diff_pipe[i-1];
                    diff_vld[i]  <= diff_vld[i-1];
                end
            end
            trig_diff       <= next_trig_diff;
            trig_diff_valid <= next_diff_valid;
            expo_tmr        <= next_expo_tmr;
            alt_phase       <= next_alt_phase;
            auto_expo       <= next_auto_expo;
            settle          <= next_settle;
            expo_time_us    <= next_expo_time;
            value_count     <= next_value_count;
            timestamp       <= next_timestamp;
        end
    end
endmodule
